/* core/graphics_digitizer_sync_output.v */
// Sync processing and pixel output timing of a graphics digitizer
// Operation
// - Line sync output realigned with pixel data
// - Line sync polarity and width settable
// - One bit selects frame sync polarity
// - Frame sync keeps source position and width; here it is sampled into each captured word and delayed with the data
// - Slicer pin: green comparator or delayed sync
// - Colour buses carry MSB on bit 7
// - Sample-to-output latency is fixed
// - Phase change moves data, clock, sync together
// - Output clock derived from sampling clock
// - Line sync is timing and frequency reference
// - Line sync polarity control selects edge
// - Only leading edge of line sync acted upon
// - Polarity zero: falling edge is active
// - Polarity one: rising edge is active
// - Slicer threshold 10 to 320 mV, 10 mV steps
// - Slicer threshold resets to 150 mV
`timescale 1ns/1ps
`default_nettype none
`include "sync_output_regs.vh"
module graphics_digitizer_sync_output #(
  parameter DW = `DATA_WIDTH,
  parameter FIFO_DEPTH = `FIFO_DEPTH,
  parameter FIFO_AW = `FIFO_AW,
  parameter HW = `HS_WIDTH_BITS,
  parameter PW = `PHASE_BITS
) (
  input wire i_sys_clk,
  input wire i_resetn,
  input wire i_line_sync_in,
  input wire i_frame_sync_in,
  input wire i_green_sync_in,
  input wire i_sample_clock,
  input wire [DW-1:0] i_red_sample,
  input wire [DW-1:0] i_green_sample,
  input wire [DW-1:0] i_blue_sample,
  input wire i_line_sync_in_pol,
  input wire i_line_sync_out_pol,
  input wire [HW-1:0] i_line_sync_out_width,
  input wire i_frame_sync_out_pol,
  input wire i_slicer_sel_green,
  input wire [`SLICE_CODE_WIDTH-1:0] i_slice_code,
  input wire i_slice_code_load,
  input wire [PW-1:0] i_sample_phase,
  output wire [`SLICE_CODE_WIDTH-1:0] o_slice_threshold,
  output reg o_line_edge_seen,
  output wire o_fifo_ready,
  output reg o_pixel_out_clock,
  output reg o_line_sync_out,
  output reg o_frame_sync_out,
  output reg o_green_sync_slicer_out,
  output reg [DW-1:0] o_red,
  output reg [DW-1:0] o_green,
  output reg [DW-1:0] o_blue
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers (two flops each)
  localparam FW = 3 * DW + 2;
  localparam ST_LOW = 2'd0;
  localparam ST_HIGH = 2'd1;
  localparam ST_FALL = 2'd2;
  reg [1:0] sclk_s;
  reg [1:0] hs_s;
  reg [1:0] vs_s;
  reg [1:0] sog_s;
  reg sclk_q;
  reg hs_q;
  reg [3*DW-1:0] samp_s1;
  reg [3*DW-1:0] samp_s2;
  // Sampling clock, its edges found on the system clock
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sclk_s <= 2'b00;
      sclk_q <= 1'b0;
    end else begin
      sclk_s <= {sclk_s[0], i_sample_clock};
      sclk_q <= sclk_s[1];
    end
  end
  // Sync pins
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hs_s <= 2'b00;
      vs_s <= 2'b00;
      sog_s <= 2'b00;
      hs_q <= 1'b0;
    end else begin
      hs_s <= {hs_s[0], i_line_sync_in};
      vs_s <= {vs_s[0], i_frame_sync_in};
      sog_s <= {sog_s[0], i_green_sync_in};
      hs_q <= hs_s[1];
    end
  end
  // Colour samples
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      samp_s1 <= {(3*DW){1'b0}};
      samp_s2 <= {(3*DW){1'b0}};
    end else begin
      samp_s1 <= {i_red_sample, i_green_sample, i_blue_sample};
      samp_s2 <= samp_s1;
    end
  end
  wire sample_tick = sclk_s[1] & ~sclk_q;

  ////////////////////////////////////////////////////////////////////////////
  // Leading-edge detection of the line sync input
  reg hs_lead;
  always @* begin
    if (i_line_sync_in_pol) begin
      hs_lead = hs_s[1] & ~hs_q;
    end else begin
      hs_lead = ~hs_s[1] & hs_q;
    end
  end
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_line_edge_seen <= 1'b0;
    end else begin
      o_line_edge_seen <= hs_lead;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Slicer threshold, code n means (n+1)*10 mV
  reg [`SLICE_CODE_WIDTH-1:0] slice_q;
  function [`SLICE_CODE_WIDTH-1:0] clamp_code;
    input [`SLICE_CODE_WIDTH-1:0] c;
    begin
      clamp_code = (c > `SLICE_CODE_MAX) ? `SLICE_CODE_MAX : c;
    end
  endfunction
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      slice_q <= `SLICE_CODE_RESET;
    end else if (i_slice_code_load) begin
      slice_q <= clamp_code(i_slice_code);
    end
  end
  assign o_slice_threshold = slice_q;

  ////////////////////////////////////////////////////////////////////////////
  // Sample capture into FIFO, tagged with syncs
  // Word: {line edge, frame sync, red, green, blue}
  reg edge_pend_q;
  reg [PW-1:0] phase_cnt_q;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [FW-1:0] fifo_out;
  reg fifo_pop;
  // Phase shifts the one strobe for all outputs
  wire capture = sample_tick & (phase_cnt_q == i_sample_phase);
  // Tick index since the last line edge
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      phase_cnt_q <= {PW{1'b0}};
    end else begin
      if (hs_lead) begin
        phase_cnt_q <= {PW{1'b0}};
      end else if (sample_tick) begin
        phase_cnt_q <= phase_cnt_q + 1'b1;
      end
    end
  end
  // Edge waits for the next stored word; a new edge wins over the clear
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      edge_pend_q <= 1'b0;
    end else begin
      if (hs_lead) begin
        edge_pend_q <= 1'b1;
      end else if (capture & fifo_in_ready) begin
        edge_pend_q <= 1'b0;
      end
    end
  end
  assign o_fifo_ready = fifo_in_ready;
  pixel_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_in_valid(capture),
    .o_in_ready(fifo_in_ready),
    .i_in_data({edge_pend_q | hs_lead, vs_s[1], samp_s2}),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output clock: one word per capture, sent on a sample tick, fixed latency
  // Line sync level for an active or idle word
  function hs_level;
    input active;
    input pol;
    begin
      hs_level = active ? pol : ~pol;
    end
  endfunction
  reg [1:0] st_q;
  reg [HW-1:0] hs_cnt_q;
  reg [HW-1:0] hs_cnt_d;
  reg line_sync_d;
  // One pop per sample tick while the strobe is idle
  always @* begin
    fifo_pop = 1'b0;
    case (st_q)
      ST_LOW: fifo_pop = fifo_out_valid & sample_tick;
      ST_HIGH: fifo_pop = 1'b0;
      default: fifo_pop = 1'b0;
    endcase
  end
  // Width counted in words, polarity applied
  always @* begin
    hs_cnt_d = hs_cnt_q;
    line_sync_d = o_line_sync_out;
    if (fifo_out[FW-1]) begin
      hs_cnt_d = i_line_sync_out_width;
      line_sync_d = hs_level(i_line_sync_out_width != {HW{1'b0}}, i_line_sync_out_pol);
    end else if (hs_cnt_q > {{(HW-1){1'b0}}, 1'b1}) begin
      hs_cnt_d = hs_cnt_q - 1'b1;
      line_sync_d = hs_level(1'b1, i_line_sync_out_pol);
    end else begin
      hs_cnt_d = {HW{1'b0}};
      line_sync_d = hs_level(1'b0, i_line_sync_out_pol);
    end
  end
  // Output strobe: data first, then clock high, then clock low
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q <= ST_LOW;
      o_pixel_out_clock <= 1'b0;
      o_line_sync_out <= 1'b0;
      o_frame_sync_out <= 1'b0;
      o_red <= {DW{1'b0}};
      o_green <= {DW{1'b0}};
      o_blue <= {DW{1'b0}};
      hs_cnt_q <= {HW{1'b0}};
    end else begin
      case (st_q)
        ST_LOW: begin
          if (fifo_pop) begin
            o_red <= fifo_out[3*DW-1:2*DW];
            o_green <= fifo_out[2*DW-1:DW];
            o_blue <= fifo_out[DW-1:0];
            // Frame sync leaves with its word, delayed through the FIFO like the data
            o_frame_sync_out <= fifo_out[FW-2] ^ i_frame_sync_out_pol;
            o_line_sync_out <= line_sync_d;
            hs_cnt_q <= hs_cnt_d;
            st_q <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          // Output clock rises after data settle
          o_pixel_out_clock <= 1'b1;
          st_q <= ST_FALL;
        end
        ST_FALL: begin
          o_pixel_out_clock <= 1'b0;
          st_q <= ST_LOW;
        end
        default: begin
          o_pixel_out_clock <= 1'b0;
          st_q <= ST_LOW;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slicer output
  reg [`SOG_DELAY_STAGES-1:0] hs_dly_q;
  // Raw line sync delay line
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hs_dly_q <= {`SOG_DELAY_STAGES{1'b0}};
    end else begin
      hs_dly_q <= {hs_dly_q[`SOG_DELAY_STAGES-2:0], hs_s[1]};
    end
  end
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_green_sync_slicer_out <= 1'b0;
    end else begin
      // Comparator or delayed raw line sync
      o_green_sync_slicer_out <= i_slicer_sel_green ? sog_s[1] :
                                 hs_dly_q[`SOG_DELAY_STAGES-1];
    end
  end
endmodule
`default_nettype wire

/* core/sync_output_regs.vh */
// Constants for the sync-processing and pixel-output block
`ifndef SYNC_OUTPUT_REGS_VH
`define SYNC_OUTPUT_REGS_VH
`define SYS_CLK_PERIOD_PS 32'd5000
`define DATA_WIDTH 8
`define DATA_MSB 7
`define SLICE_STEP_MV 10
`define SLICE_MIN_MV 10
`define SLICE_MAX_MV 330
`define SLICE_RESET_MV 150
`define SLICE_CODE_WIDTH 5
`define SLICE_CODE_RESET 5'h0e
`define SLICE_CODE_MAX 5'h1f
`define HS_WIDTH_BITS 8
`define HS_WIDTH_RESET 8'h20
`define PHASE_BITS 5
`define SOG_DELAY_STAGES 4
`define FIFO_DEPTH 8
`define FIFO_AW 3
`define CTRL_ADDR 8'h0e
`define CTRL_HS_POL_BIT 6
`endif

/* core/pixel_fifo_mem.v */
// Small register-output memory used as the FIFO store
`timescale 1ns/1ps
`default_nettype none
module pixel_fifo_mem #(
  parameter WIDTH = 26,
  parameter AW = 3
) (
  input wire i_sys_clk,
  input wire i_wr_en,
  input wire [AW-1:0] i_wr_addr,
  input wire [WIDTH-1:0] i_wr_data,
  input wire [AW-1:0] i_rd_addr,
  output reg [WIDTH-1:0] o_rd_data
);
  reg [WIDTH-1:0] mem [0:(1<<AW)-1];
  always @(posedge i_sys_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
    o_rd_data <= mem[i_rd_addr];
  end
endmodule
`default_nettype wire

/* core/pixel_fifo.v */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module pixel_fifo #(
  parameter WIDTH = 26,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire i_sys_clk,
  input wire i_resetn,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [AW:0] wr_q;
  reg [AW:0] rd_q;
  reg [AW:0] cnt_q;
  wire [WIDTH-1:0] mem_rd;
  wire do_wr;
  wire do_rd;
  wire [AW:0] rd_next;
  reg fresh_q;
  // Memory read is registered, so look ahead one address on a pop
  assign o_in_ready = (cnt_q != DEPTH[AW:0]);
  // A word written into the slot being read shows one cycle later
  assign o_out_valid = (cnt_q != {(AW+1){1'b0}}) & ~fresh_q;
  assign do_wr = i_in_valid & o_in_ready;
  assign do_rd = o_out_valid & i_out_ready;
  assign rd_next = do_rd ? rd_q + 1'b1 : rd_q;
  assign o_out_data = mem_rd;
  pixel_fifo_mem #(.WIDTH(WIDTH), .AW(AW)) u_mem (
    .i_sys_clk(i_sys_clk),
    .i_wr_en(do_wr),
    .i_wr_addr(wr_q[AW-1:0]),
    .i_wr_data(i_in_data),
    .i_rd_addr(rd_next[AW-1:0]),
    .o_rd_data(mem_rd)
  );
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fresh_q <= 1'b0;
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      fresh_q <= do_wr & (wr_q[AW-1:0] == rd_next[AW-1:0]);
      if (do_wr) begin
        wr_q <= wr_q + 1'b1;
      end
      rd_q <= rd_next;
      cnt_q <= cnt_q + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
    end
  end
endmodule
`default_nettype wire

/* testbench/graphics_digitizer_sync_output_properties.sv */
// Port assertions for the sync output block
`timescale 1ns/1ps
`default_nettype none
module sync_output_checker (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_line_sync_in,
  input wire logic i_green_sync_in,
  input wire logic i_line_sync_in_pol,
  input wire logic i_slicer_sel_green,
  input wire logic [4:0] o_slice_threshold,
  input wire logic o_line_edge_seen,
  input wire logic o_pixel_out_clock,
  input wire logic o_green_sync_slicer_out,
  input wire logic [7:0] o_red,
  input wire logic [7:0] o_green,
  input wire logic [7:0] o_blue
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  wire [23:0] pix = {o_red, o_green, o_blue};
  property p_thr_rst; $rose(i_resetn) |-> o_slice_threshold == 5'h0e; endproperty
  a_thr_rst: assert property (p_thr_rst) else $error("bad reset threshold");
  property p_clk_hi; $rose(o_pixel_out_clock) |=> !o_pixel_out_clock; endproperty
  a_clk_hi: assert property (p_clk_hi) else $error("clock high too long");
  property p_pix_hold; $rose(o_pixel_out_clock) |-> $stable(pix) ##1 $stable(pix); endproperty
  a_pix_hold: assert property (p_pix_hold) else $error("data moved at clock");
  property p_lead_r;
    i_line_sync_in_pol && $rose(i_line_sync_in) |-> ##[1:6] o_line_edge_seen;
  endproperty
  a_lead_r: assert property (p_lead_r) else $error("rising edge missed");
  property p_lead_f;
    !i_line_sync_in_pol && $fell(i_line_sync_in) |-> ##[1:6] o_line_edge_seen;
  endproperty
  a_lead_f: assert property (p_lead_f) else $error("falling edge missed");
  property p_trail;
    (i_line_sync_in_pol ? $fell(i_line_sync_in) : $rose(i_line_sync_in))
      |=> !o_line_edge_seen [*5];
  endproperty
  a_trail: assert property (p_trail) else $error("trailing edge used");
  property p_sl_green;
    i_slicer_sel_green && $rose(i_green_sync_in) |-> ##[1:5] o_green_sync_slicer_out;
  endproperty
  a_sl_green: assert property (p_sl_green) else $error("slicer lost");
  property p_sl_delay;
    !i_slicer_sel_green && $rose(i_line_sync_in) |-> ##[4:10] o_green_sync_slicer_out;
  endproperty
  a_sl_delay: assert property (p_sl_delay) else $error("sync copy lost");
  c_edge: cover property (o_line_edge_seen);
  c_word: cover property ($rose(o_pixel_out_clock));
  c_green: cover property (i_slicer_sel_green && o_green_sync_slicer_out);
endmodule
bind graphics_digitizer_sync_output sync_output_checker i_chk (
  .i_sys_clk, .i_resetn, .i_line_sync_in, .i_green_sync_in, .i_line_sync_in_pol,
  .i_slicer_sel_green, .o_slice_threshold, .o_line_edge_seen, .o_pixel_out_clock,
  .o_green_sync_slicer_out, .o_red, .o_green, .o_blue
);
`default_nettype wire

/* testbench/scaler_capture.sv */
// Downstream capture model for pixel words
`timescale 1ns/1ps
`default_nettype none
module scaler_capture (
  input wire logic i_pix_clk,
  input wire logic [25:0] i_word,
  output logic [25:0] o_word,
  output logic [15:0] o_count
);
  initial o_count = 16'h0000;
  always @(posedge i_pix_clk) begin
    o_word <= i_word;
    o_count <= o_count + 16'h0001;
  end
endmodule
`default_nettype wire

/* testbench/graphics_digitizer_sync_output_tb.sv */
// Self-checking bench for the sync output block
`timescale 1ns/1ps
`default_nettype none
module graphics_digitizer_sync_output_tb;
  logic i_sys_clk = 1'b0, i_resetn = 1'b0, i_line_sync_in = 1'b0, i_frame_sync_in = 1'b0;
  logic i_green_sync_in = 1'b0, i_sample_clock = 1'b0, i_slicer_sel_green = 1'b0;
  logic i_line_sync_in_pol = 1'b1, i_line_sync_out_pol = 1'b1, i_frame_sync_out_pol = 1'b0;
  logic i_slice_code_load = 1'b0;
  logic [4:0] i_slice_code = 5'h00, i_sample_phase = 5'h02;
  logic [7:0] i_red_sample = 8'h00, i_green_sample = 8'h00, i_blue_sample = 8'h00;
  logic [7:0] i_line_sync_out_width = 8'h00;
  wire [4:0] o_slice_threshold;
  wire [7:0] o_red, o_green, o_blue;
  wire o_line_edge_seen, o_fifo_ready, o_pixel_out_clock, o_line_sync_out, o_frame_sync_out;
  wire o_green_sync_slicer_out;
  wire [25:0] cap_w;
  wire [15:0] cap_n;
  int err_count = 0, tests_run = 0, edges = 0, cycles = 0, n0 = 0;
  graphics_digitizer_sync_output i_dut (
    .i_sys_clk, .i_resetn, .i_line_sync_in, .i_frame_sync_in, .i_green_sync_in,
    .i_sample_clock, .i_red_sample, .i_green_sample, .i_blue_sample, .i_line_sync_in_pol,
    .i_line_sync_out_pol, .i_line_sync_out_width, .i_frame_sync_out_pol,
    .i_slicer_sel_green, .i_slice_code, .i_slice_code_load, .i_sample_phase,
    .o_slice_threshold, .o_line_edge_seen, .o_fifo_ready, .o_pixel_out_clock,
    .o_line_sync_out, .o_frame_sync_out, .o_green_sync_slicer_out, .o_red, .o_green, .o_blue
  );
  scaler_capture i_cap (
    .i_pix_clk(o_pixel_out_clock),
    .i_word({o_line_sync_out, o_frame_sync_out, o_red, o_green, o_blue}),
    .o_word(cap_w),
    .o_count(cap_n)
  );
  always #2.5 i_sys_clk = ~i_sys_clk;
  always #24 i_sample_clock = ~i_sample_clock;
  always @(posedge i_sys_clk) if (o_line_edge_seen === 1'b1) edges++;
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      give_verdict;
    end
  end
  task give_verdict;
    if (err_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  task t_slice;
    // Controls change only a few ports at a time, far apart
    for (int c = 0; c < 32; c += 31) begin
      i_slice_code = c[4:0];
      i_slice_code_load = 1'b1;
      cyc(1);
      i_slice_code_load = 1'b0;
      cyc(2);
      check(o_slice_threshold, c[4:0]);
    end
  endtask
  task t_edges;
    for (int p = 0; p < 2; p++) begin
      i_line_sync_in_pol = p[0];
      cyc(8);
      i_line_sync_in = ~p[0];
      cyc(12);
      n0 = edges;
      i_line_sync_in = p[0];
      cyc(12);
      check(edges - n0, 1);
      i_line_sync_in = ~p[0];
      cyc(12);
      check(edges - n0, 1);
    end
  endtask
  task t_slicer;
    i_slicer_sel_green = 1'b1;
    i_green_sync_in = 1'b1;
    cyc(6);
    check(o_green_sync_slicer_out, 1'b1);
    i_green_sync_in = 1'b0;
    cyc(6);
    check(o_green_sync_slicer_out, 1'b0);
    i_slicer_sel_green = 1'b0;
    i_line_sync_in = ~i_line_sync_in;
    cyc(12);
    check(o_green_sync_slicer_out, i_line_sync_in);
  endtask
  task t_data;
    for (int p = 0; p < 2; p++) begin
      {i_red_sample, i_green_sample, i_blue_sample} = 24'h80_015a ^ {24{p[0]}};
      i_frame_sync_out_pol = p[0];
      i_line_sync_out_pol = ~p[0];
      i_sample_phase = p[0] ? 5'h05 : 5'h02;
      i_frame_sync_in = 1'b1;
      i_line_sync_in = 1'b0;
      cyc(40);
      n0 = cap_n;
      i_line_sync_in = 1'b1;
      for (int i = 0; i < 400 && cap_n == n0; i++) cyc(1);
      check(cap_w, {p[0], ~p[0], 24'h80_015a ^ {24{p[0]}}});
    end
  endtask
  task t_width;
    i_line_sync_out_pol = 1'b1;
    i_line_sync_out_width = 8'h02;
    i_line_sync_in = 1'b0;
    cyc(40);
    n0 = cap_n;
    for (int i = 0; i < 400 && cap_n == n0; i++) cyc(1);
    i_line_sync_in = 1'b1;
    for (int k = 0; k < 3; k++) begin
      n0 = cap_n;
      for (int i = 0; i < 400 && cap_n == n0; i++) cyc(1);
      check(cap_w[25], k < 2);
    end
  endtask
  initial begin
    repeat (8) @(negedge i_sys_clk);
    i_resetn = 1'b1;
    cyc(3);
    check(o_slice_threshold, 5'h0e);
    t_slice;
    t_edges;
    t_slicer;
    t_data;
    t_width;
    give_verdict;
  end
endmodule
`default_nettype wire
